// [design/ppm_cap_word.sv]
// Capability word: fixed fields, loaded aux field and strap-driven field
`timescale 1ns/100ps
module ppm_cap_word import ppm_pkg::*; (
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Loader and strap
    input  wire logic        aux_load,
    input  wire logic [2:0]  aux_data,
    input  wire logic        cold_wake_strap,
    // Assembled word
    output logic [15:0]      cap_word
);

    logic [2:0] aux_q;
    logic       strap_q;

    // ======================================================
    // Aux field only moves on a loader strobe, never from the bus
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aux_q <= PPM_AUX_RST;
        end else if (ce && aux_load) begin
            aux_q <= aux_data;
        end
    end

    // Strap is caught by the clock, after reset release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strap_q <= PPM_STRAP_RST;
        end else if (ce) begin
            strap_q <= cold_wake_strap;
        end
    end

    always_comb begin
        cap_word = 16'h0000;
        cap_word[PPM_VER_LSB +: 3]  = PPM_VERSION;
        cap_word[PPM_AUX_LSB +: 3]  = aux_q;
        cap_word[PPM_D1_BIT]        = 1'h1;
        cap_word[PPM_D2_BIT]        = 1'h1;
        cap_word[PPM_WSUP_LSB +: 5] = {strap_q, PPM_WAKE_WARM};
    end

    a_aux_load_path:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && aux_load |=> cap_word[PPM_AUX_LSB +: 3] == $past(aux_data))
    else $error("aux field did not take loaded value");

endmodule

// [design/ppm_regs.sv]
// Power management capability and control/status registers
`timescale 1ns/100ps

// Operation
// - Capability bits 2-0 always read 010 and ignore writes.
// - Capability bits 3, 4 and 5 always read zero.
// - Aux power bits 8-6 reset to 000, load from the ROM image only.
// - Aux codes 111..001 mean 375,320,270,220,160,100,55 mA; 000 none.
// - Capability bits 9 and 10 always read one.
// - Bits 15-11 read 11111 with the cold strap high, else 01111.
// - Bits 11..15 map D0,D1,D2,D3hot,D3cold; zero forbids waking there.
// - Control bits 1-0 hold the power state, written and read back.
// - In D0 DMA and link run and an active interrupt raises wake.
// - In D1 DMA stops, link runs, an active interrupt raises wake.
// - In D2/D3 DMA, link and link power request stop; link-on wakes.
// - Control bits 12-9 and 14-13 always read zero.
// - Control bit 15 clears on a written one, zero is ignored.
module ppm_regs import ppm_pkg::*; (
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Configuration access
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [1:0]  cfg_be,
    input  wire logic [15:0] cfg_wdata,
    output logic [15:0]      cfg_rdata,
    // ROM loader and strap
    input  wire logic        aux_load,
    input  wire logic [2:0]  aux_data,
    input  wire logic        cold_wake_strap,
    // Wake sources
    input  wire logic        intr_active,
    input  wire logic        phy_wake_indication,
    // Link power request from the link side
    input  wire logic        link_power_want,
    // Power-state controls
    output logic             dma_run,
    output logic             link_run,
    output logic             link_power_request,
    output logic [8:0]       aux_current_ma,
    // Open-drain wake pin
    output logic             wake_pin_o,
    output logic             wake_pin_oe
);

    // ======================================================
    // Internal signals
    ppm_ctrl_s   ctrl_q;
    ppm_pstate_e state_q;
    logic        en_q;
    logic        flag_q;
    logic [15:0] cap_word;
    logic [15:0] rdata_q;
    logic        wake_event;
    logic        wr_csr;
    logic        dma_run_q;
    logic        link_run_q;
    logic        lpr_q;
    logic        pin_oe_q;
    logic [8:0]  aux_ma_q;

    // Control/status word as seen by the host
    function automatic logic [15:0] csr_pack(input ppm_ctrl_s c);
        logic [15:0] w;
        w = 16'h0000;
        w[PPM_PS_LSB +: 2] = c.state;
        w[PPM_EN_BIT]      = c.enable;
        w[PPM_FLAG_BIT]    = c.flag;
        return w;
    endfunction

    // ======================================================
    // Submodules
    ppm_cap_word u_cap (
        .core_clk        (core_clk),
        .rst             (rst),
        .ce              (ce),
        .aux_load        (aux_load),
        .aux_data        (aux_data),
        .cold_wake_strap (cold_wake_strap),
        .cap_word        (cap_word)
    );

    ppm_wake_ctl u_wake (
        .core_clk            (core_clk),
        .rst                 (rst),
        .ce                  (ce),
        .state               (ctrl_q.state),
        .wake_capable_states (cap_word[PPM_WSUP_LSB +: 5]),
        .intr_active         (intr_active),
        .phy_wake_indication (phy_wake_indication),
        .wake_event          (wake_event)
    );

    // ======================================================
    // Write decode
    // Only the halfword at the control offset holds writable bits;
    // writes to the capability word are dropped.
    assign wr_csr = ce && cfg_wr && (cfg_addr == PPM_CSR_OFS);

    // ======================================================
    // Power state
    // Reset value is left open by the host contract; D0 is chosen
    // so that the controller comes up running.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= PPM_D0;
        end else if (wr_csr && cfg_be[0]) begin
            state_q <= ppm_pstate_e'(cfg_wdata[PPM_PS_LSB +: 2]);
        end
    end

    // ======================================================
    // Wake enable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_q <= PPM_EN_RST;
        end else if (wr_csr && cfg_be[1]) begin
            en_q <= cfg_wdata[PPM_EN_BIT];
        end
    end

    // ======================================================
    // Wake flag: a wake in the same cycle as a clear wins,
    // so no event is lost to a racing acknowledge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_q <= PPM_FLAG_RST;
        end else if (wake_event) begin
            flag_q <= 1'h1;
        end else if (wr_csr && cfg_be[1] && cfg_wdata[PPM_FLAG_BIT]) begin
            flag_q <= 1'h0;
        end
    end

    // ======================================================
    // Read path, one cycle latency; unmapped offsets read zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (ce && cfg_rd) begin
            case (cfg_addr)
                PPM_CAP_OFS: rdata_q <= cap_word;
                PPM_CSR_OFS: rdata_q <= csr_pack(ctrl_q);
                default:     rdata_q <= 16'h0000;
            endcase
        end
    end

    assign cfg_rdata = rdata_q;

    // Host view of the control fields; each field has its own process
    // so that no two processes write one variable
    assign ctrl_q = '{flag: flag_q, enable: en_q, state: state_q};

    // ======================================================
    // Power-state effects on DMA, link and link power request
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dma_run_q <= 1'h0;
        end else if (ce) begin
            dma_run_q <= (ctrl_q.state == PPM_D0);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_run_q <= 1'h0;
        end else if (ce) begin
            link_run_q <= ctrl_q.state inside {PPM_D0, PPM_D1};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lpr_q <= 1'h0;
        end else if (ce) begin
            lpr_q <= link_power_want
                     && ctrl_q.state inside {PPM_D0, PPM_D1};
        end
    end

    // ======================================================
    // Wake pin: drives low only while flag and enable are both set
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_oe_q <= 1'h0;
        end else if (ce) begin
            pin_oe_q <= ctrl_q.flag && ctrl_q.enable;
        end
    end

    // ======================================================
    // Aux current report for the board power controller
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aux_ma_q <= 9'h000;
        end else if (ce) begin
            aux_ma_q <= ppm_aux_ma(cap_word[PPM_AUX_LSB +: 3]);
        end
    end

    assign dma_run            = dma_run_q;
    assign link_run           = link_run_q;
    assign link_power_request = lpr_q;
    assign aux_current_ma     = aux_ma_q;
    assign wake_pin_o         = 1'h0;
    assign wake_pin_oe        = pin_oe_q;

    // ======================================================
    // Checks
    a_cap_version:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && cfg_rd && cfg_addr == PPM_CAP_OFS
        |=> cfg_rdata[PPM_VER_LSB +: 3] == PPM_VERSION)
    else $error("capability version wrong");

    a_cap_zero_bits:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && cfg_rd && cfg_addr == PPM_CAP_OFS
        |=> cfg_rdata[PPM_DSI_BIT:PPM_CLK_BIT] == 3'h0)
    else $error("capability bits 5-3 not zero");

    a_d1_d2_support:
    assert property (@(posedge core_clk) disable iff (rst)
        cap_word[PPM_D2_BIT:PPM_D1_BIT] == 2'h3)
    else $error("D1/D2 support bits not set");

    a_strap_to_field:
    assert property (@(posedge core_clk) disable iff (rst)
        ce ##1 ce |=> cap_word[PPM_WSUP_LSB +: 5]
                     == {$past(cold_wake_strap), PPM_WAKE_WARM})
    else $error("wake-capable field does not follow strap");

    a_aux_report:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && cap_word[PPM_AUX_LSB +: 3] == 3'h7 |=> aux_current_ma == 9'h177)
    else $error("aux current report wrong");

    a_state_write:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_csr && cfg_be[0] ##1 ce && cfg_rd && cfg_addr == PPM_CSR_OFS
        |=> cfg_rdata[PPM_PS_LSB +: 2] == $past(cfg_wdata[1:0], 2))
    else $error("power state not read back");

    a_dma_gate:
    assert property (@(posedge core_clk) disable iff (rst)
        ce |=> dma_run == ($past(ctrl_q.state) == PPM_D0))
    else $error("DMA run does not follow D0");

    a_link_gate:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && ctrl_q.state == PPM_D1 |=> link_run && !dma_run)
    else $error("D1 link/DMA gating wrong");

    a_low_state_lpr:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && ctrl_q.state inside {PPM_D2, PPM_D3}
        |=> !link_power_request && !link_run)
    else $error("link power request alive in D2/D3");

    a_csr_reserved:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && cfg_rd && cfg_addr == PPM_CSR_OFS
        |=> cfg_rdata[7:2] == 6'h00 && cfg_rdata[14:9] == 6'h00)
    else $error("reserved control bits not zero");

    a_enable_write:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_csr && cfg_be[1] |=> ctrl_q.enable == $past(cfg_wdata[PPM_EN_BIT]))
    else $error("wake enable not written");

    a_flag_clear:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_csr && cfg_be[1] && cfg_wdata[PPM_FLAG_BIT] && !wake_event
        |=> !ctrl_q.flag)
    else $error("flag not cleared by written one");

    a_flag_set_wins:
    assert property (@(posedge core_clk) disable iff (rst)
        wake_event |=> ctrl_q.flag)
    else $error("wake event lost");

    a_pin_drive:
    assert property (@(posedge core_clk) disable iff (rst)
        ce |=> wake_pin_oe == ($past(ctrl_q.flag) && $past(ctrl_q.enable)))
    else $error("wake pin drive mismatch");

    a_zero_keeps_flag:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_csr && !cfg_wdata[PPM_FLAG_BIT] && !wake_event
        |=> ctrl_q.flag == $past(ctrl_q.flag))
    else $error("flag changed by written zero");

    a_lpr_follows_want:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && ctrl_q.state inside {PPM_D0, PPM_D1}
        |=> link_power_request == $past(link_power_want))
    else $error("link power request does not follow link side");

    a_freeze_holds:
    assert property (@(posedge core_clk) disable iff (rst)
        !ce |=> ctrl_q == $past(ctrl_q) && cfg_rdata == $past(cfg_rdata))
    else $error("state moved while clock enable low");

endmodule

// [design/ppm_wake_ctl.sv]
// Wake condition selection by power state
`timescale 1ns/100ps
module ppm_wake_ctl import ppm_pkg::*; (
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Context
    input  ppm_pstate_e      state,
    input  wire logic [4:0]  wake_capable_states,
    // Sources
    input  wire logic        intr_active,
    input  wire logic        phy_wake_indication,
    // Event
    output logic             wake_event
);

    logic phy_q;
    logic cond;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phy_q <= 1'h0;
        end else if (ce) begin
            phy_q <= phy_wake_indication;
        end
    end

    // ======================================================
    // D3 can only be D3hot while this logic is powered
    always_comb begin
        case (state)
            PPM_D0:  cond = intr_active
                         && wake_capable_states[0];
            PPM_D1:  cond = intr_active
                         && wake_capable_states[1];
            PPM_D2:  cond = phy_wake_indication
                         && !phy_q && wake_capable_states[2];
            PPM_D3:  cond = phy_wake_indication
                         && !phy_q && wake_capable_states[3];
            default: cond = 1'h0;
        endcase
        wake_event = ce && cond;
    end

    a_link_on_edge:
    assert property (@(posedge core_clk) disable iff (rst)
        ce && state inside {PPM_D2, PPM_D3}
        && $rose(phy_wake_indication) |-> wake_event)
    else $error("link-on edge in low state gave no wake");

endmodule

// [shared/ppm_pkg.sv]
// Power management capability register constants, types and helpers
package ppm_pkg;

    // ======================================================
    // Configuration space byte offsets
    localparam logic [7:0] PPM_CAP_OFS     = 8'h62;
    localparam logic [7:0] PPM_CSR_OFS     = 8'h64;

    // ======================================================
    // Capability word field positions
    localparam int         PPM_VER_LSB     = 0;
    localparam int         PPM_CLK_BIT     = 3;
    localparam int         PPM_RSV_BIT     = 4;
    localparam int         PPM_DSI_BIT     = 5;
    localparam int         PPM_AUX_LSB     = 6;
    localparam int         PPM_D1_BIT      = 9;
    localparam int         PPM_D2_BIT      = 10;
    localparam int         PPM_WSUP_LSB    = 11;

    // ======================================================
    // Control/status word field positions
    localparam int         PPM_PS_LSB      = 0;
    localparam int         PPM_EN_BIT      = 8;
    localparam int         PPM_SEL_LSB     = 9;
    localparam int         PPM_SCALE_LSB   = 13;
    localparam int         PPM_FLAG_BIT    = 15;

    // ======================================================
    // Fixed and reset values
    localparam logic [2:0] PPM_VERSION     = 3'h2;
    localparam logic [2:0] PPM_AUX_RST     = 3'h0;
    localparam logic [3:0] PPM_WAKE_WARM   = 4'hf;
    localparam logic       PPM_EN_RST      = 1'h0;
    localparam logic       PPM_FLAG_RST    = 1'h0;
    localparam logic       PPM_STRAP_RST   = 1'h0;

    // ======================================================
    // Types
    typedef enum logic [1:0] {
        PPM_D0,
        PPM_D1,
        PPM_D2,
        PPM_D3
    } ppm_pstate_e;

    typedef struct packed {
        logic        flag;
        logic        enable;
        ppm_pstate_e state;
    } ppm_ctrl_s;

    // Auxiliary supply current in mA for a field code
    function automatic logic [8:0] ppm_aux_ma(input logic [2:0] code);
        case (code)
            3'h7:    ppm_aux_ma = 9'h177;
            3'h6:    ppm_aux_ma = 9'h140;
            3'h5:    ppm_aux_ma = 9'h10e;
            3'h4:    ppm_aux_ma = 9'h0dc;
            3'h3:    ppm_aux_ma = 9'h0a0;
            3'h2:    ppm_aux_ma = 9'h064;
            3'h1:    ppm_aux_ma = 9'h037;
            default: ppm_aux_ma = 9'h000;
        endcase
    endfunction

endpackage

// [testbench/ppm_host.sv]
// Host side model: configuration cycles and the pulled-up wake line
`timescale 1ns/100ps
module ppm_host (
    // Clock
    input  wire logic        core_clk,
    // Configuration access
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic [7:0]       cfg_addr,
    output logic [1:0]       cfg_be,
    output logic [15:0]      cfg_wdata,
    input  wire logic [15:0] cfg_rdata,
    // Wake line
    input  wire logic        wake_pin_o,
    input  wire logic        wake_pin_oe,
    output wire logic        wake_n
);
    // Board pull-up holds the line high whenever nobody pulls it down
    assign wake_n = wake_pin_oe ? wake_pin_o : 1'b1;

    initial begin
        cfg_rd    = 1'b0;
        cfg_wr    = 1'b0;
        cfg_addr  = 8'h00;
        cfg_be    = 2'h0;
        cfg_wdata = 16'h0000;
    end

    // Called just after a rising edge; strobe is taken at the next edge
    task automatic wr(input logic [7:0] a, input logic [1:0] be,
                      input logic [15:0] d);
        cfg_wr    = 1'b1;
        cfg_addr  = a;
        cfg_be    = be;
        cfg_wdata = d;
        @(posedge core_clk);
        #2;
        cfg_wr    = 1'b0;
        cfg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        cfg_rd   = 1'b1;
        cfg_addr = a;
        @(posedge core_clk);
        #2;
        cfg_rd   = 1'b0;
        d        = cfg_rdata;
    endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the power management register block
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
    import ppm_pkg::*;
    // ======================================================
    // Signals
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        ce       = 1'b1;
    logic        aux_load = 1'b0;
    logic [2:0]  aux_data = 3'h0;
    logic        strap    = 1'b0;
    logic        intr     = 1'b0;
    logic        phy      = 1'b0;
    logic        want     = 1'b1;
    logic        cfg_rd, cfg_wr;
    logic [7:0]  cfg_addr;
    logic [1:0]  cfg_be;
    logic [15:0] cfg_wdata, cfg_rdata, rv;
    logic        dma_run, link_run, lpr, pin_o, pin_oe;
    wire logic   wake_n;
    logic [8:0]  aux_ma;
    logic [8:0]  ma_tab [0:7] = '{9'h000, 9'h037, 9'h064, 9'h0a0,
                                  9'h0dc, 9'h10e, 9'h140, 9'h177};
    int          n_mismatch  = 0;
    int          checks_done = 0;

    always #12.5 core_clk = ~core_clk;

    ppm_regs dut_u (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .aux_load(aux_load), .aux_data(aux_data),
        .cold_wake_strap(strap), .intr_active(intr),
        .phy_wake_indication(phy), .link_power_want(want),
        .dma_run(dma_run), .link_run(link_run),
        .link_power_request(lpr), .aux_current_ma(aux_ma),
        .wake_pin_o(pin_o), .wake_pin_oe(pin_oe)
    );

    ppm_host host_u (
        .core_clk(core_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .wake_pin_o(pin_o),
        .wake_pin_oe(pin_oe), .wake_n(wake_n)
    );

    // ======================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ======================================================
    // Scenarios
    task automatic t_reset_values;
        host_u.rd(8'h62, rv);
        `CHK(rv, 16'h7e02)
        `CHK(rv[5:3], 3'h0)
        `CHK(rv[10:9], 2'h3)
        `CHK(rv[15:11], 5'h0f)
        `CHK(aux_ma, 9'h000)
        // An edge passes so the read strobe is not lowered and raised at once
        cyc(1);
        host_u.rd(8'h64, rv);
        `CHK(rv, 16'h0000)
        `CHK({dma_run, link_run}, 2'h3)
        cyc(1);
        host_u.rd(8'h70, rv);
        `CHK(rv, 16'h0000)
    endtask

    task automatic t_cap_read_only;
        host_u.wr(8'h62, 2'h3, 16'h81fd);
        host_u.rd(8'h62, rv);
        `CHK(rv, 16'h7e02)
        strap = 1'b1;
        cyc(2);
        host_u.rd(8'h62, rv);
        `CHK(rv, 16'hfe02)
        `CHK(rv[15], 1'b1)
        strap = 1'b0;
        cyc(2);
    endtask

    task automatic t_aux_codes;
        for (int c = 7; c >= 0; c--) begin
            aux_data = c[2:0];
            aux_load = 1'b1;
            cyc(1);
            aux_load = 1'b0;
            aux_data = ~c[2:0];
            cyc(2);
            `CHK(aux_ma, ma_tab[c])
            host_u.rd(8'h62, rv);
            `CHK(rv[8:6], c[2:0])
        end
    endtask

    task automatic t_csr_fields;
        host_u.wr(8'h64, 2'h3, 16'h7ffc);
        host_u.rd(8'h64, rv);
        `CHK(rv, 16'h0100)
        `CHK(rv[14:9], 6'h00)
        host_u.wr(8'h64, 2'h2, 16'h0000);
        host_u.rd(8'h64, rv);
        `CHK(rv, 16'h0000)
        // A write while the clock enable is low must leave no trace
        ce = 1'b0;
        host_u.wr(8'h64, 2'h3, 16'h0103);
        ce = 1'b1;
        host_u.rd(8'h64, rv);
        `CHK(rv, 16'h0000)
    endtask

    task automatic t_states;
        logic [1:0] s;
        // Link side drops its request while the link runs in D0
        want = 1'b0;
        cyc(2);
        `CHK(lpr, 1'b0)
        want = 1'b1;
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            host_u.wr(8'h64, 2'h1, {14'h0, s});
            cyc(2);
            `CHK(dma_run, s == 2'h0)
            `CHK(link_run, s < 2'h2)
            `CHK(lpr, s < 2'h2)
            host_u.rd(8'h64, rv);
            `CHK(rv, {14'h0, s})
        end
        host_u.wr(8'h64, 2'h2, 16'h0000);
        host_u.rd(8'h64, rv);
        `CHK(rv[1:0], 2'h3)
    endtask

    task automatic pulse_and_check(input logic [1:0] s, input logic use_phy,
                                   input logic en, input logic hit);
        host_u.wr(8'h64, 2'h3, {7'h40, en, 6'h00, s});
        if (use_phy)
            phy = 1'b1;
        else
            intr = 1'b1;
        cyc(1);
        intr = 1'b0;
        cyc(3);
        host_u.rd(8'h64, rv);
        `CHK(rv[15], hit)
        `CHK(wake_n, !(hit && en))
        phy = 1'b0;
        host_u.wr(8'h64, 2'h2, {7'h00, en, 8'h00});
        host_u.rd(8'h64, rv);
        `CHK(rv[15], hit)
        host_u.wr(8'h64, 2'h2, {7'h40, en, 8'h00});
        cyc(2);
        host_u.rd(8'h64, rv);
        `CHK(rv[15], 1'b0)
        `CHK(wake_n, 1'b1)
    endtask

    task automatic t_wake;
        pulse_and_check(2'h0, 1'b0, 1'b1, 1'b1);
        pulse_and_check(2'h1, 1'b0, 1'b1, 1'b1);
        pulse_and_check(2'h2, 1'b1, 1'b1, 1'b1);
        pulse_and_check(2'h3, 1'b1, 1'b1, 1'b1);
        pulse_and_check(2'h3, 1'b0, 1'b1, 1'b0);
        pulse_and_check(2'h1, 1'b1, 1'b1, 1'b0);
        pulse_and_check(2'h2, 1'b0, 1'b1, 1'b0);
        pulse_and_check(2'h0, 1'b0, 1'b0, 1'b1);
    endtask

    // Reset in mid-run must undo a written state, enable and aux code
    task automatic t_mid_reset;
        host_u.wr(8'h64, 2'h3, 16'h0103);
        aux_data = 3'h7;
        aux_load = 1'b1;
        cyc(1);
        aux_load = 1'b0;
        rst      = 1'b1;
        cyc(3);
        rst = 1'b0;
        cyc(1);
        `CHK({dma_run, link_run}, 2'h3)
        `CHK(aux_ma, 9'h000)
        host_u.rd(8'h64, rv);
        `CHK(rv, 16'h0000)
        cyc(1);
        host_u.rd(8'h62, rv);
        `CHK(rv[8:6], 3'h0)
    endtask

    // ======================================================
    // Sequence
    initial begin
        repeat (12) @(posedge core_clk);
        #2;
        rst = 1'b0;
        cyc(1);
        t_reset_values();
        t_cap_read_only();
        t_aux_codes();
        t_csr_fields();
        t_states();
        t_wake();
        t_mid_reset();
        print_verdict();
    end

    // Whole run needs under two hundred cycles; this leaves wide margin
    initial begin
        #(25 * 5000);
        n_mismatch++;
        print_verdict();
    end
endmodule
